/* pc_card_host_port_pins_tb.sv */
// Testbench joining both ends.
// Assumes all other files compile first.
`timescale 1ns/10ps
module pc_card_host_port_pins_tb;
    import pch_pkg::*;
    // Clock, reset and counters
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    int failures = 0;
    int check_count = 0;
    int cycles = 0; // Timeout count
    int wait_cnt = 0; // Samples with wait asserted
    int wr_cnt = 0; // Write acceptance pulses
    // Device core side
    logic [15:0] mem_data_pins = 16'hA5C3;
    logic io_mode = 1'b0, init_done = 1'b0, irq_req = 1'b0, status_event = 1'b0;
    logic [15:0] rd_data, wr_data, strap_direction_reg;
    logic [9:0] acc_addr;
    logic [1:0] wr_bytes;
    logic wr_strobe, wr_attr, cable_attached, usb_dp_o, usb_dp_oe_n, usb_dm_o, usb_dm_oe_n, port_l_bit5, port_l_bit6;
    logic [2:0] boot_select;
    // Shared pin sources
    logic [1:0] pin_mux_sel = MUX_USB, mem_addr_hi = 2'h2, port_l_oe_n_cfg = 2'h1;
    logic usb_dp_in = 1'b1, usb_dm_in = 1'b0, usb_dp_drv = 1'b1, usb_dm_drv = 1'b0, usb_drv_en = 1'b1;
    logic port_l_bit5_out = 1'b1, port_l_bit6_out = 1'b1, usb_detect = 1'b0;
    // Host user side
    logic req_valid = 1'b0, req_write = 1'b0, req_attr = 1'b0;
    logic [9:0] req_addr = 10'h000;
    logic [1:0] req_bytes = 2'h3;
    logic [15:0] req_wdata = 16'h0000, rdata;
    logic req_ready, done, decoded, irq_or_ready, status_changed;
    // Read data pattern keyed by the taken address
    assign rd_data = {acc_addr, 6'h15};
    always #12.5 clk_sys = ~clk_sys;
    pch_if u_pch_if();
    pch_device u_pch_device (.clk_sys, .reset, .pins(u_pch_if), .mem_data_pins, .io_mode, .init_done, .irq_req,
        .status_event, .rd_data, .acc_addr, .wr_data, .wr_bytes, .wr_strobe, .wr_attr, .strap_direction_reg,
        .boot_select, .pin_mux_sel, .usb_dp_in, .usb_dm_in, .usb_dp_drv, .usb_dm_drv, .usb_drv_en, .mem_addr_hi,
        .port_l_bit5_out, .port_l_bit6_out, .port_l_oe_n_cfg, .usb_dp_o, .usb_dp_oe_n, .usb_dm_o, .usb_dm_oe_n,
        .port_l_bit5, .port_l_bit6, .usb_detect, .cable_attached);
    pch_host u_pch_host (.clk_sys, .reset, .pins(u_pch_if), .req_valid, .req_write, .req_attr, .req_addr,
        .req_bytes, .req_wdata, .req_ready, .done, .rdata, .decoded, .irq_or_ready, .status_changed);
    pch_port_monitor u_pch_port_monitor (.clk_sys, .reset, .io_mode, .init_done, .irq_req, .status_event,
        .mem_data_pins, .strap_direction_reg, .host_addr_in(u_pch_if.host_addr_in),
        .low_byte_select_n(u_pch_if.low_byte_select_n), .high_byte_select_n(u_pch_if.high_byte_select_n),
        .io_read_strobe_n(u_pch_if.io_read_strobe_n), .io_write_strobe_n(u_pch_if.io_write_strobe_n),
        .attr_output_enable_n(u_pch_if.attr_output_enable_n), .attr_write_enable_n(u_pch_if.attr_write_enable_n),
        .attr_space_select_n(u_pch_if.attr_space_select_n), .host_data_d_o(u_pch_if.host_data_d_o),
        .host_data_d_oe_n(u_pch_if.host_data_d_oe_n), .io_decode_ack_n(u_pch_if.io_decode_ack_n),
        .host_wait_n(u_pch_if.host_wait_n), .host_ready_or_irq_n(u_pch_if.host_ready_or_irq_n),
        .status_change_n(u_pch_if.status_change_n));
    // Counters and hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (u_pch_if.host_wait_n === 1'b0) wait_cnt <= wait_cnt + 1;
        if (wr_strobe === 1'b1) wr_cnt <= wr_cnt + 1;
        if (cycles == 3000) begin
            failures++;
            $display("[ERR] %0t run timed out", $time);
            end_of_test();
        end
    end
    // Compare one value and report a mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // One host access; returns read data and decode flag
    task automatic access(input logic wr, input logic attr, input logic [9:0] a, input logic [1:0] b,
        input logic [15:0] wd, output logic [15:0] rd, output logic dec);
        int n;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (req_ready !== 1'b1 && n < 20);
        wait_cnt = 0;
        req_valid <= 1'b1; req_write <= wr; req_attr <= attr; req_addr <= a; req_bytes <= b; req_wdata <= wd;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        do begin @(posedge clk_sys); n++; end while (done !== 1'b1 && n < 40);
        rd = rdata;
        dec = decoded;
        chk(n < 40, 1, "access completes");
    endtask : access
    // Strap capture, with a second reset
    task automatic t_straps();
        chk(strap_direction_reg, 16'hA5C3, "strap word");
        chk(boot_select, 3'h5, "boot field");
        mem_data_pins <= STRAP_DEFAULT; reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (3) @(posedge clk_sys);
        mem_data_pins <= 16'h0000;
        repeat (3) @(posedge clk_sys);
        chk(strap_direction_reg, STRAP_DEFAULT, "default straps");
        chk(boot_select, BOOT_SERIAL_EEPROM, "default boot");
        $display("test straps done");
    endtask : t_straps
    // I/O read at the window edge, then writes with each byte select set
    task automatic t_io();
        logic [15:0] rd;
        logic dec;
        int w0;
        access(1'b0, 1'b0, 10'h03F, 2'h3, 16'h0000, rd, dec);
        chk(rd, {10'h03F, 6'h15}, "io read data");
        chk(dec, 1, "io decode");
        chk(wait_cnt, ACCESS_CYC, "wait length");
        w0 = wr_cnt;
        for (int b = 1; b < 4; b++) begin
            access(1'b1, 1'b0, 10'h020 + b, b, 16'hC3A0 + b, rd, dec);
            chk(wr_bytes, b, "byte lanes");
            chk(wr_data, 16'hC3A0 + b, "write data");
            chk({wr_attr, acc_addr}, 10'h020 + b, "write place");
        end
        chk(wr_cnt - w0, 3, "write pulses");
        $display("test io done");
    endtask : t_io
    // Attribute access, then an I/O miss
    task automatic t_attr_miss();
        logic [15:0] rd;
        logic dec;
        access(1'b1, 1'b1, 10'h3FF, 2'h1, 16'h5A5A, rd, dec);
        chk({wr_attr, acc_addr, wr_data}, {1'b1, 10'h3FF, 16'h5A5A}, "attr write");
        access(1'b0, 1'b1, 10'h3FF, 2'h1, 16'h0000, rd, dec);
        chk({dec, rd}, {1'b0, 10'h3FF, 6'h15}, "attr read");
        access(1'b0, 1'b0, 10'h040, 2'h3, 16'h0000, rd, dec);
        chk({dec, rd}, 17'h00000, "io miss");
        chk(wait_cnt, 0, "no wait on miss");
        $display("test attr and miss done");
    endtask : t_attr_miss
    // Ready or irq per mode, status pulse
    task automatic t_status();
        for (int k = 0; k < 4; k++) begin
            io_mode <= k[1]; init_done <= k[0] && !k[1]; irq_req <= k[0] && k[1];
            repeat (4) @(posedge clk_sys);
            chk(irq_or_ready, k[0], "ready or irq");
        end
        status_event <= 1'b1;
        @(posedge clk_sys);
        status_event <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(status_changed, 1, "status pulse");
        repeat (4) @(posedge clk_sys);
        chk(status_changed, 0, "status clear");
        $display("test status done");
    endtask : t_status
    // Shared pins in each mux mode, and cable detect
    task automatic t_mux();
        logic [1:0] exp_o [3] = '{2'h2, 2'h1, 2'h3};
        logic [1:0] exp_oe [3] = '{2'h0, 2'h0, 2'h2};
        for (int m = 0; m < 3; m++) begin
            pin_mux_sel <= m; usb_detect <= m[0];
            repeat (3) @(posedge clk_sys);
            chk({usb_dp_o, usb_dm_o}, exp_o[m], "mux value");
            chk({usb_dp_oe_n, usb_dm_oe_n}, exp_oe[m], "mux enable");
            chk(cable_attached, m[0], "cable detect");
        end
        chk({port_l_bit5, port_l_bit6}, 2'h2, "port inputs");
        $display("test mux done");
    endtask : t_mux
    // Count summary and verdict
    task automatic end_of_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (3) @(posedge clk_sys);
        t_straps();
        t_io();
        t_attr_miss();
        t_status();
        t_mux();
        end_of_test();
    end
endmodule : pc_card_host_port_pins_tb

/* pch_device.sv */
// Device end of the card host port.
// Assumes inputs synchronous to clk_sys.
//
// What this block does
// - I/O mode: shared output is interrupt request
// - Memory mode: shared output is ready after init
// - First clock after reset copies straps
// - Clock runs before reset is released
// - Wait asserted while transfer incomplete
// - I/O decode acknowledged on acknowledge output
// - Host drives ten address bits
// - Sixteen-bit data; device drives only reads
// - Card selects pick low, high byte
// - Separate I/O read and write strobes
// - Attribute space uses select plus enables
// - Status change output signals card changes
// - Two shared pins: bus, address, port
// - Cable detect senses bus power
// - No straps fitted selects serial EEPROM boot
`timescale 1ns/10ps
module pch_device
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Card pins
    pch_if.device pins,
    // Local memory data pins sampled as straps
    input wire logic [pch_pkg::STRAP_W-1:0] mem_data_pins,
    // Core side
    input wire logic io_mode, // High once card is switched to I/O mode
    input wire logic init_done, // Card initialisation finished
    input wire logic irq_req, // Core interrupt level
    input wire logic status_event, // Core status change level
    input wire logic [pch_pkg::DATA_W-1:0] rd_data, // Read data for the addressed word
    output logic [pch_pkg::ADDR_W-1:0] acc_addr, // Address of the taken access
    output logic [pch_pkg::DATA_W-1:0] wr_data, // Write data of the taken access
    output logic [1:0] wr_bytes, // Byte lanes written, bit 1 high byte
    output logic wr_strobe, // One-cycle pulse on write acceptance
    output logic wr_attr, // Write was to attribute space
    // Straps
    output logic [pch_pkg::STRAP_W-1:0] strap_direction_reg,
    output logic [2:0] boot_select,
    // Shared differential pins
    input wire logic [1:0] pin_mux_sel,
    input wire logic usb_dp_in,
    input wire logic usb_dm_in,
    input wire logic usb_dp_drv,
    input wire logic usb_dm_drv,
    input wire logic usb_drv_en,
    input wire logic [21:20] mem_addr_hi,
    input wire logic port_l_bit5_out,
    input wire logic port_l_bit6_out,
    input wire logic [1:0] port_l_oe_n_cfg, // Port direction, low drives
    output logic usb_dp_o,
    output logic usb_dp_oe_n,
    output logic usb_dm_o,
    output logic usb_dm_oe_n,
    output logic port_l_bit5,
    output logic port_l_bit6,
    // Cable detect
    input wire logic usb_detect,
    output logic cable_attached
);
    import pch_pkg::*;

    pch_state_t state_r; // Access state
    logic [1:0] cnt_r; // Access latency counter
    logic strap_pend_r; // Strap capture still owed after reset
    logic status_d_r; // Previous status level
    logic sel; // Any card select active
    logic io_rd, io_wr, at_rd, at_wr; // Strobe decode
    logic io_hit; // I/O access inside card window
    logic access; // Any valid access in progress

    // Function: card window decode
    function automatic logic in_window(input logic [9:0] a);
        in_window = ((a & IO_MASK) == IO_BASE);
    endfunction : in_window

    // Strobe decode
    assign sel = !pins.low_byte_select_n || !pins.high_byte_select_n;
    assign io_rd = sel && !pins.io_read_strobe_n;
    assign io_wr = sel && !pins.io_write_strobe_n;
    assign at_rd = sel && !pins.attr_space_select_n && !pins.attr_output_enable_n;
    assign at_wr = sel && !pins.attr_space_select_n && !pins.attr_write_enable_n;
    assign io_hit = (io_rd || io_wr) && in_window(pins.host_addr_in);
    assign access = io_hit || at_rd || at_wr;

    // Access sequencer and wait output
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= PCH_IDLE;
            cnt_r <= 2'h0;
            pins.host_wait_n <= 1'b1;
        end else begin
            case (state_r)
                PCH_IDLE: begin
                    if (access) begin
                        state_r <= PCH_BUSY;
                        cnt_r <= 2'(ACCESS_CYC - 1);
                        pins.host_wait_n <= 1'b0;
                    end
                end
                PCH_BUSY: begin
                    if (!access) begin
                        state_r <= PCH_IDLE; // Host abandoned the cycle
                        pins.host_wait_n <= 1'b1;
                    end else if (cnt_r == 2'h0) begin
                        state_r <= PCH_DONE;
                        pins.host_wait_n <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r - 2'h1;
                    end
                end
                PCH_DONE: begin
                    if (!access) begin
                        state_r <= PCH_IDLE;
                    end
                end
                default: begin
                    state_r <= PCH_IDLE;
                    pins.host_wait_n <= 1'b1;
                end
            endcase
        end
    end

    // Read data drive during selected reads
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pins.host_data_d_o <= 16'h0000;
            pins.host_data_d_oe_n <= 1'b1;
        end else begin
            pins.host_data_d_oe_n <= !((io_rd && io_hit) || at_rd);
            if (state_r == PCH_BUSY && cnt_r == 2'h0) begin
                pins.host_data_d_o <= rd_data;
            end
        end
    end

    // I/O decode acknowledge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pins.io_decode_ack_n <= 1'b1;
        end else begin
            pins.io_decode_ack_n <= !io_hit;
        end
    end

    // Write capture
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            acc_addr <= 10'h000;
            wr_data <= 16'h0000;
            wr_bytes <= 2'h0;
            wr_strobe <= 1'b0;
            wr_attr <= 1'b0;
        end else begin
            wr_strobe <= 1'b0;
            if (state_r == PCH_IDLE && access) begin
                acc_addr <= pins.host_addr_in;
            end
            if (state_r == PCH_BUSY && cnt_r == 2'h0 && access && (io_wr || at_wr)) begin
                wr_data <= pins.host_data_bus;
                wr_bytes <= {!pins.high_byte_select_n, !pins.low_byte_select_n};
                wr_strobe <= 1'b1;
                wr_attr <= at_wr;
            end
        end
    end

    // Shared ready or interrupt output
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pins.host_ready_or_irq_n <= 1'b0; // Driven low (ready) during reset
        end else if (io_mode) begin
            pins.host_ready_or_irq_n <= !irq_req;
        end else begin
            pins.host_ready_or_irq_n <= !init_done; // (low = ready, high = busy)
        end
    end

    // Status change level
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_d_r <= 1'b0;
            pins.status_change_n <= 1'b1;
        end else begin
            status_d_r <= status_event;
            pins.status_change_n <= !(status_event || status_d_r);
        end
    end

    // Strap capture on the first clock after reset release
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            strap_pend_r <= 1'b1;
            strap_direction_reg <= STRAP_DEFAULT;
            boot_select <= BOOT_SERIAL_EEPROM;
        end else if (strap_pend_r) begin
            strap_pend_r <= 1'b0;
            strap_direction_reg <= mem_data_pins;
            boot_select <= mem_data_pins[STRAP_BOOT_MSB:STRAP_BOOT_LSB];
        end
    end

    // Shared differential pins mux
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            usb_dp_o <= 1'b0;
            usb_dm_o <= 1'b0;
            usb_dp_oe_n <= 1'b1;
            usb_dm_oe_n <= 1'b1;
            port_l_bit5 <= 1'b0;
            port_l_bit6 <= 1'b0;
        end else begin
            port_l_bit5 <= usb_dp_in;
            port_l_bit6 <= usb_dm_in;
            case (pin_mux_sel)
                MUX_USB: begin
                    usb_dp_o <= usb_dp_drv;
                    usb_dm_o <= usb_dm_drv;
                    usb_dp_oe_n <= !usb_drv_en;
                    usb_dm_oe_n <= !usb_drv_en;
                end
                MUX_ADDR: begin
                    usb_dp_o <= mem_addr_hi[20];
                    usb_dm_o <= mem_addr_hi[21];
                    usb_dp_oe_n <= 1'b0;
                    usb_dm_oe_n <= 1'b0;
                end
                MUX_PORT: begin
                    usb_dp_o <= port_l_bit5_out;
                    usb_dm_o <= port_l_bit6_out;
                    usb_dp_oe_n <= port_l_oe_n_cfg[0];
                    usb_dm_oe_n <= port_l_oe_n_cfg[1];
                end
                default: begin
                    usb_dp_oe_n <= 1'b1;
                    usb_dm_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // Cable detect sample
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cable_attached <= 1'b0;
        end else begin
            cable_attached <= usb_detect;
        end
    end
endmodule : pch_device

/* pch_host.sv */
// Host end: one I/O or attribute access at a time.
// Assumes the device end shares clk_sys.
`timescale 1ns/10ps
module pch_host
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Card pins
    pch_if.host pins,
    // User request
    input wire logic req_valid, // Start an access when idle
    input wire logic req_write, // High write, low read
    input wire logic req_attr, // High attribute space, low I/O space
    input wire logic [pch_pkg::ADDR_W-1:0] req_addr,
    input wire logic [1:0] req_bytes, // Bit 0 low byte, bit 1 high byte
    input wire logic [pch_pkg::DATA_W-1:0] req_wdata,
    // User answer
    output logic req_ready, // High when idle
    output logic done, // One-cycle pulse at end of access
    output logic [pch_pkg::DATA_W-1:0] rdata,
    output logic decoded, // Device acknowledged an I/O decode
    output logic irq_or_ready, // Shared ready/irq, active high
    output logic status_changed // Status change, active high
);
    import pch_pkg::*;

    typedef enum logic [1:0] {PCH_H_IDLE, PCH_H_SETUP, PCH_H_STROBE, PCH_H_END} pch_hstate_t;
    pch_hstate_t state_r; // Host cycle state
    logic write_r; // Access is a write
    logic attr_r; // Access is attribute space

    // Host cycle: setup, strobe until wait high, then release
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= PCH_H_IDLE;
            write_r <= 1'b0;
            attr_r <= 1'b0;
            req_ready <= 1'b1;
            done <= 1'b0;
            rdata <= 16'h0000;
            decoded <= 1'b0;
            pins.host_addr_in <= 10'h000;
            pins.low_byte_select_n <= 1'b1;
            pins.high_byte_select_n <= 1'b1;
            pins.io_read_strobe_n <= 1'b1;
            pins.io_write_strobe_n <= 1'b1;
            pins.attr_output_enable_n <= 1'b1;
            pins.attr_write_enable_n <= 1'b1;
            pins.attr_space_select_n <= 1'b1;
            pins.host_data_h_o <= 16'h0000;
            pins.host_data_h_oe_n <= 1'b1;
        end else begin
            done <= 1'b0;
            case (state_r)
                PCH_H_IDLE: begin
                    if (req_valid) begin
                        state_r <= PCH_H_SETUP;
                        req_ready <= 1'b0;
                        write_r <= req_write;
                        attr_r <= req_attr;
                        decoded <= 1'b0;
                        pins.host_addr_in <= req_addr;
                        pins.low_byte_select_n <= !req_bytes[0];
                        pins.high_byte_select_n <= !req_bytes[1];
                        pins.attr_space_select_n <= !req_attr;
                        pins.host_data_h_o <= req_wdata;
                        pins.host_data_h_oe_n <= !req_write;
                    end
                end
                PCH_H_SETUP: begin
                    state_r <= PCH_H_STROBE;
                    pins.io_read_strobe_n <= !(!attr_r && !write_r);
                    pins.io_write_strobe_n <= !(!attr_r && write_r);
                    pins.attr_output_enable_n <= !(attr_r && !write_r);
                    pins.attr_write_enable_n <= !(attr_r && write_r);
                end
                PCH_H_STROBE: begin
                    if (!pins.io_decode_ack_n) begin
                        decoded <= 1'b1;
                    end
                    if (pins.host_wait_n) begin
                        state_r <= PCH_H_END;
                    end
                end
                PCH_H_END: begin
                    // Wait high seen two edges in a row: data is stable
                    if (pins.host_wait_n) begin
                        rdata <= pins.host_data_bus;
                        done <= 1'b1;
                        state_r <= PCH_H_IDLE;
                        req_ready <= 1'b1;
                        pins.io_read_strobe_n <= 1'b1;
                        pins.io_write_strobe_n <= 1'b1;
                        pins.attr_output_enable_n <= 1'b1;
                        pins.attr_write_enable_n <= 1'b1;
                        pins.attr_space_select_n <= 1'b1;
                        pins.low_byte_select_n <= 1'b1;
                        pins.high_byte_select_n <= 1'b1;
                        pins.host_data_h_oe_n <= 1'b1;
                    end else begin
                        state_r <= PCH_H_STROBE;
                    end
                end
                default: begin
                    state_r <= PCH_H_IDLE;
                end
            endcase
        end
    end

    // Status inputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_or_ready <= 1'b0;
            status_changed <= 1'b0;
        end else begin
            irq_or_ready <= !pins.host_ready_or_irq_n;
            status_changed <= !pins.status_change_n;
        end
    end
endmodule : pch_host

/* pch_if.sv */
// Card pins between host and device ends.
// Assumes each end drives only its own enable.
`timescale 1ns/10ps
interface pch_if;
    logic [9:0] host_addr_in;
    logic low_byte_select_n;
    logic high_byte_select_n;
    logic io_read_strobe_n;
    logic io_write_strobe_n;
    logic attr_output_enable_n;
    logic attr_write_enable_n;
    logic attr_space_select_n;
    logic [15:0] host_data_h_o; // Host drive value
    logic host_data_h_oe_n; // Host drive enable, low drives
    logic [15:0] host_data_d_o; // Device drive value
    logic host_data_d_oe_n; // Device drive enable, low drives
    logic [15:0] host_data_bus; // Resolved bus level
    logic io_decode_ack_n;
    logic host_wait_n;
    logic host_ready_or_irq_n;
    logic status_change_n;
    always_comb begin
        // Resolve the shared data wires; floating reads as zero (pull downs)
        if (!host_data_d_oe_n) begin
            host_data_bus = host_data_d_o;
        end else if (!host_data_h_oe_n) begin
            host_data_bus = host_data_h_o;
        end else begin
            host_data_bus = 16'h0000;
        end
    end
    modport device (
        input host_addr_in, low_byte_select_n, high_byte_select_n, io_read_strobe_n, io_write_strobe_n,
        input attr_output_enable_n, attr_write_enable_n, attr_space_select_n, host_data_bus,
        output host_data_d_o, host_data_d_oe_n, io_decode_ack_n, host_wait_n,
        output host_ready_or_irq_n, status_change_n
    );
    modport host (
        output host_addr_in, low_byte_select_n, high_byte_select_n, io_read_strobe_n, io_write_strobe_n,
        output attr_output_enable_n, attr_write_enable_n, attr_space_select_n, host_data_h_o, host_data_h_oe_n,
        input host_data_bus, io_decode_ack_n, host_wait_n, host_ready_or_irq_n, status_change_n
    );
endinterface : pch_if

/* pch_pkg.sv */
// Shared constants and types for both ends.
// Assumes one 40 MHz system clock.
package pch_pkg;
    // Bus widths
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int STRAP_W = 16;
    // Clock period in ns and the device's access latency
    localparam int CLK_PERIOD_NS = 25;
    localparam int ACCESS_NS = 75;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Card I/O window: base and address mask in address words
    localparam logic [9:0] IO_BASE = 10'h000;
    localparam logic [9:0] IO_MASK = 10'h3C0;
    // Strap field positions within the captured word
    localparam int STRAP_BOOT_LSB = 13;
    localparam int STRAP_BOOT_MSB = 15;
    // Boot selection code with no external straps (internal pull levels)
    localparam logic [2:0] BOOT_SERIAL_EEPROM = 3'h0;
    // Strap word produced by internal pulls alone
    localparam logic [15:0] STRAP_DEFAULT = 16'h10FF;
    // Shared pin mux selects
    localparam logic [1:0] MUX_USB = 2'h0;
    localparam logic [1:0] MUX_ADDR = 2'h1;
    localparam logic [1:0] MUX_PORT = 2'h2;
    // Device access state
    typedef enum logic [1:0] {PCH_IDLE, PCH_BUSY, PCH_DONE} pch_state_t;
endpackage : pch_pkg

/* pch_port_monitor.sv */
// Checker on the card pins.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/10ps
module pch_port_monitor
    import pch_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Host driven pins
    input wire logic [9:0] host_addr_in,
    input wire logic low_byte_select_n,
    input wire logic high_byte_select_n,
    input wire logic io_read_strobe_n,
    input wire logic io_write_strobe_n,
    input wire logic attr_output_enable_n,
    input wire logic attr_write_enable_n,
    input wire logic attr_space_select_n,
    // Device driven pins
    input wire logic [15:0] host_data_d_o,
    input wire logic host_data_d_oe_n,
    input wire logic io_decode_ack_n,
    input wire logic host_wait_n,
    input wire logic host_ready_or_irq_n,
    input wire logic status_change_n,
    // Device core levels and straps
    input wire logic io_mode,
    input wire logic init_done,
    input wire logic irq_req,
    input wire logic status_event,
    input wire logic [15:0] mem_data_pins,
    input wire logic [15:0] strap_direction_reg
);
    logic sel; // Either byte selected
    logic io_hit; // I/O strobe inside the card window
    logic acc; // Any decoded access
    logic rd_any; // Any read strobe with a select
    assign sel = !low_byte_select_n || !high_byte_select_n;
    assign io_hit = sel && (!io_read_strobe_n || !io_write_strobe_n) && ((host_addr_in & IO_MASK) == IO_BASE);
    assign acc = io_hit || (sel && !attr_space_select_n && (!attr_output_enable_n || !attr_write_enable_n));
    assign rd_any = sel && (!io_read_strobe_n || (!attr_space_select_n && !attr_output_enable_n));
    // All checks on the system clock, idle during reset
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_ack_follows_hit: assert property (1 |=> io_decode_ack_n == !$past(io_hit))
        else $error("decode ack does not follow the decode");
    a_wait_length: assert property ($rose(acc) |=> !host_wait_n [*3] ##1 host_wait_n)
        else $error("wait length wrong");
    a_wait_idle_high: assert property (!acc |=> host_wait_n)
        else $error("wait asserted without an access");
    a_drive_on_read: assert property ($rose(rd_any && acc) |=> !host_data_d_oe_n)
        else $error("read not driven");
    a_float_no_read: assert property (!rd_any |=> host_data_d_oe_n)
        else $error("data driven without a read");
    a_data_held: assert property (!host_data_d_oe_n && host_wait_n && $past(!host_data_d_oe_n && host_wait_n)
        |-> $stable(host_data_d_o))
        else $error("read data moved after wait release");
    a_ready_irq_mode: assert property ($past(!reset) |->
        host_ready_or_irq_n == !$past(io_mode ? irq_req : init_done))
        else $error("ready or irq level wrong");
    a_status_low: assert property ($rose(status_event) |=> !status_change_n [*2])
        else $error("status change not signalled");
    a_strap_capture: assert property ($fell(reset) |=> strap_direction_reg == $past(mem_data_pins))
        else $error("straps not captured");
endmodule : pch_port_monitor
